/* File: bench/two_wire_wiper_slave_interface_tb_top.sv */
// Self-checking bench for the two-wire wiper slave
`timescale 1ns/1ps
module two_wire_wiper_slave_interface_tb_top;
  localparam int NVW = 200;

  logic        clk;
  logic        rst_n;
  logic [2:0]  strap;
  logic        wp_n;
  logic        scl;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe;
  logic [63:0] tap;
  logic [5:0]  wiper;
  logic        busy;
  logic        busy_seen;
  logic [5:0]  wv [3] = '{6'h00, 6'h3F, 6'h15};
  int          error_cnt = 0;
  int          tests_run = 0;
  // Pull-up resolves the open-drain data line
  wire         sda_w = ~(sda_low | (sda_oe & ~sda_o));

  always #4 clk = ~clk;
  always @(posedge clk) if (busy === 1'b1) busy_seen <= 1'b1;

  twsp_top #(.NVWRITE_CYC(NVW)) i_dut (
    .clk_i(clk), .nrst_i(rst_n), .ce_i(1'b1), .scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .addr_strap_bit0_i(strap[0]), .addr_strap_bit2_i(strap[1]), .addr_strap_bit3_i(strap[2]),
    .wr_prot_n_i(wp_n), .tap_sel_o(tap), .wiper_position_reg_o(wiper), .nv_busy_o(busy));

  twsp_bus_master i_mst (.sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [7:0] adr();
    return {twsp_pkg::DEV_TYPE_ID, strap[2], strap[1], twsp_pkg::ADDR_BIT1, strap[0]};
  endfunction

  task automatic send(input logic [23:0] b, input int n, output logic [2:0] ak);
    ak = 3'h0;
    i_mst.start_c();
    for (int k = 0; k < n; k++) begin
      i_mst.wr_byte(b[23-8*k -: 8], ak[2-k]);
    end
    i_mst.stop_c();
    #200;
  endtask

  task automatic fetch(input logic [7:0] c, output logic [7:0] d);
    logic [1:0] a2;
    i_mst.start_c();
    i_mst.wr_byte(adr(), a2[1]);
    i_mst.wr_byte(c, a2[0]);
    i_mst.rd_byte(d);
    i_mst.stop_c();
    #200;
    chk("read_acks", 64'h3, 64'(a2));
  endtask

  task automatic poll();
    logic [2:0] ak;
    int         nacks;
    nacks = 0;
    for (int k = 0; k < 20; k++) begin
      send({adr(), 16'h0}, 1, ak);
      if (ak[2] === 1'b1) break;
      nacks++;
    end
    chk("poll_refused", 64'h1, 64'(nacks != 0));
    chk("poll_acked", 64'h1, 64'(ak[2]));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    chk("wiper", 64'(twsp_pkg::STORE_RST), 64'(wiper));
    chk("tap", 64'h1 << twsp_pkg::STORE_RST, tap);
    $display("t_power_up done");
  endtask

  task automatic t_address();
    logic [2:0] ak;
    for (int s = 0; s < 8; s++) begin
      @(negedge clk) strap = 3'(s);
      #100;
      send({adr(), 16'h0}, 1, ak);
      chk("addr_ack", 64'h4, 64'(ak));
      send({adr() ^ 8'h01, 16'h0}, 1, ak);
      chk("strap_miss", 64'h0, 64'(ak));
    end
    send({adr() ^ 8'h80, 16'h0}, 1, ak);
    chk("id_miss", 64'h0, 64'(ak));
    send({adr() ^ 8'h02, 16'h0}, 1, ak);
    chk("bit1_miss", 64'h0, 64'(ak));
    // Address byte without a start must be ignored
    i_mst.wr_byte(adr(), ak[0]);
    i_mst.stop_c();
    #200;
    chk("no_start", 64'h0, 64'(ak[0]));
    $display("t_address done");
  endtask

  task automatic t_wiper();
    logic [2:0] ak;
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      send({adr(), twsp_pkg::OP_WR_WPOS, 4'h0, 2'b00, wv[i]}, 3, ak);
      chk("wr_acks", 64'h7, 64'(ak));
      chk("wiper", 64'(wv[i]), 64'(wiper));
      chk("tap", 64'h1 << wv[i], tap);
      fetch({twsp_pkg::OP_RD_WPOS, 4'h0}, d);
      chk("rd_wiper", 64'({2'b00, wv[i]}), 64'(d));
    end
    send({adr(), twsp_pkg::OP_STEP, 4'h1, 8'h00}, 2, ak);
    chk("step_acks", 64'h6, 64'(ak));
    send({adr(), twsp_pkg::OP_WR_WPOS, 4'h4, 8'h3F}, 3, ak);
    chk("bad_sel", 64'h4, 64'(ak));
    send({adr(), twsp_pkg::OP_RD_WPOS, 4'h1, 8'h00}, 2, ak);
    chk("bad_low", 64'h4, 64'(ak));
    send({adr(), 8'h30, 8'h00}, 2, ak);
    chk("bad_op", 64'h4, 64'(ak));
    chk("wiper_kept", 64'h15, 64'(wiper));
    $display("t_wiper done");
  endtask

  task automatic t_store();
    logic [2:0] ak;
    logic [7:0] d;
    busy_seen = 1'b0;
    send({adr(), twsp_pkg::OP_WR_STORE, 2'd2, 2'b00, 8'h2A}, 3, ak);
    chk("st_acks", 64'h7, 64'(ak));
    poll();
    chk("busy_seen", 64'h1, 64'(busy_seen));
    fetch({twsp_pkg::OP_RD_STORE, 2'd2, 2'b00}, d);
    chk("store2", 64'h2A, 64'(d));
    send({adr(), twsp_pkg::OP_XFR_LOAD, 2'd2, 2'b00, 8'h00}, 2, ak);
    chk("load", 64'h2A, 64'(wiper));
    send({adr(), twsp_pkg::OP_XFR_SAVE, 2'd3, 2'b00, 8'h00}, 2, ak);
    poll();
    fetch({twsp_pkg::OP_RD_STORE, 2'd3, 2'b00}, d);
    chk("store3", 64'h2A, 64'(d));
    $display("t_store done");
  endtask

  task automatic t_protect();
    logic [2:0] ak;
    logic [7:0] d;
    @(negedge clk) wp_n = 1'b0;
    #100;
    busy_seen = 1'b0;
    send({adr(), twsp_pkg::OP_WR_STORE, 2'd1, 2'b00, 8'h11}, 3, ak);
    chk("wp_acks", 64'h7, 64'(ak));
    #2000;
    chk("wp_busy", 64'h0, 64'(busy_seen));
    fetch({twsp_pkg::OP_RD_STORE, 2'd1, 2'b00}, d);
    chk("store1", 64'({2'b00, twsp_pkg::STORE_RST}), 64'(d));
    @(negedge clk) wp_n = 1'b1;
    $display("t_protect done");
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk       = 1'b0;
    rst_n     = 1'b0;
    strap     = 3'h5;
    wp_n      = 1'b1;
    busy_seen = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_power_up();
    t_address();
    t_wiper();
    t_store();
    t_protect();
    test_done();
  end

  // About forty frames near 1.7 us each; some seven times that margin
  initial begin
    #500000;
    error_cnt++;
    test_done();
  end
endmodule

/* File: bench/twsp_bus_master.sv */
// Behavioural two-wire bus master driving clock and open-drain data
`timescale 1ns/1ps
module twsp_bus_master (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // Clock stands high between frames
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Low phase 48 ns, high 32 ns: each level lasts over three system clocks,
  // and data moves only after the slave's late release has landed
  task automatic bit_x(input logic b, output logic s);
    scl_o = 1'b0;
    #40 sda_low_o = ~b;
    #8 scl_o = 1'b1;
    #16 s = sda_i;
    #16 scl_o = 1'b0;
  endtask

  task automatic start_c();
    sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #24 sda_low_o = 1'b1;
    #24 scl_o = 1'b0;
  endtask

  task automatic stop_c();
    #40 sda_low_o = 1'b1;
    #8 scl_o = 1'b1;
    #24 sda_low_o = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  // Always ends with a refusal: the slave sends one byte only
  task automatic rd_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(1'b1, s);
  endtask
endmodule

/* File: bench/twsp_monitor.sv */
// Concurrent checks on the two-wire wiper slave ports
`timescale 1ns/1ps
module twsp_monitor #(
  parameter int NVWRITE_CYC = 20
) (
  input wire logic                          clk_i,
  input wire logic                          nrst_i,
  input wire logic                          ce_i,
  input wire logic                          scl_clk_i,
  input wire logic                          sda_i,
  input wire logic                          sda_o,
  input wire logic                          sda_oe_o,
  input wire logic                          addr_strap_bit0_i,
  input wire logic                          addr_strap_bit2_i,
  input wire logic                          addr_strap_bit3_i,
  input wire logic                          wr_prot_n_i,
  input wire logic [twsp_pkg::NUM_TAPS-1:0] tap_sel_o,
  input wire logic [twsp_pkg::WPOS_W-1:0]   wiper_position_reg_o,
  input wire logic                          nv_busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic [23:0] busy_cnt_r;

  // Busy length is far beyond any repetition count, so it is counted here
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt_r <= 24'h0;
    end else if (nv_busy_o) begin
      busy_cnt_r <= busy_cnt_r + 24'h1;
    end else begin
      busy_cnt_r <= 24'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_pull_low_only: assert property (sda_oe_o |-> sda_o == 1'b0) else $error("data line driven high");
  a_tap_one_hot: assert property ($onehot(tap_sel_o)) else $error("tap select not one-hot");
  a_tap_decode: assert property ($past(ce_i) |-> tap_sel_o == (64'h1 << $past(wiper_position_reg_o)))
    else $error("tap select does not match wiper");
  a_quiet_busy: assert property (nv_busy_o |-> !sda_oe_o) else $error("acknowledge while busy");
  a_busy_len: assert property ($fell(nv_busy_o) |-> busy_cnt_r >= NVWRITE_CYC && busy_cnt_r <= NVWRITE_CYC + 1)
    else $error("write cycle length wrong");
  a_busy_after_stop: assert property ($rose(nv_busy_o) |-> scl_clk_i && sda_i)
    else $error("write cycle began without stop");
  a_protect_holds: assert property ($rose(nv_busy_o) |-> wr_prot_n_i && $past(wr_prot_n_i, 4))
    else $error("write cycle while protected");
  a_change_clk_low: assert property ($changed(sda_oe_o) |-> !scl_clk_i)
    else $error("data line changed with clock high");
  a_ack_release: assert property ($rose(sda_oe_o) |-> ##[1:200] !sda_oe_o)
    else $error("data line never released");
  a_power_recall: assert property ($rose(nrst_i) |-> ##[0:3] wiper_position_reg_o == twsp_pkg::STORE_RST)
    else $error("stored setting not recalled");

  c_busy: cover property ($rose(nv_busy_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_wiper: cover property ($changed(wiper_position_reg_o));
endmodule

bind twsp_top twsp_monitor #(.NVWRITE_CYC(NVWRITE_CYC)) u_mon (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .addr_strap_bit0_i(addr_strap_bit0_i), .addr_strap_bit2_i(addr_strap_bit2_i),
  .addr_strap_bit3_i(addr_strap_bit3_i), .wr_prot_n_i(wr_prot_n_i), .tap_sel_o(tap_sel_o),
  .wiper_position_reg_o(wiper_position_reg_o), .nv_busy_o(nv_busy_o));

/* File: design/twsp_pkg.sv */
// Shared constants, types and encodings for the two-wire wiper slave
package twsp_pkg;

  // Timing: system clock period and nonvolatile write busy time
  localparam int CLK_PERIOD_NS   = 8;
  localparam int T_NVWRITE_NS    = 5000000;
  localparam int NVWRITE_CYCLES  = (T_NVWRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVWRITE_CNT_W   = 24;

  // Widths and sizes
  localparam int WPOS_W          = 6;
  localparam int NUM_TAPS        = 64;
  localparam int NUM_STORE       = 4;
  localparam int SEL_W           = 2;

  // Slave address byte layout
  localparam logic [3:0] DEV_TYPE_ID  = 4'hA;  // Arbitrary value
  localparam logic       ADDR_BIT1    = 1'h0;
  localparam int         ID_MSB       = 7;
  localparam int         ID_LSB       = 4;
  localparam int         ADR_BIT3_POS = 3;
  localparam int         ADR_BIT2_POS = 2;
  localparam int         ADR_BIT1_POS = 1;
  localparam int         ADR_BIT0_POS = 0;

  // Command byte layout
  localparam int         OP_MSB       = 7;
  localparam int         OP_LSB       = 4;
  localparam int         RSEL_MSB     = 3;
  localparam int         RSEL_LSB     = 2;

  // Instruction codes
  localparam logic [3:0] OP_RD_WPOS   = 4'h9;
  localparam logic [3:0] OP_WR_WPOS   = 4'hA;
  localparam logic [3:0] OP_RD_STORE  = 4'hB;
  localparam logic [3:0] OP_WR_STORE  = 4'hC;
  localparam logic [3:0] OP_XFR_LOAD  = 4'hD;
  localparam logic [3:0] OP_XFR_SAVE  = 4'hE;
  localparam logic [3:0] OP_STEP      = 4'h2;

  // Reset values
  localparam logic [WPOS_W-1:0]   WPOS_RST  = 6'h00;
  localparam logic [WPOS_W-1:0]   STORE_RST = 6'h20;
  localparam logic [NUM_TAPS-1:0] TAP_RST   = 64'h0000000000000001;

  typedef enum logic [3:0] {
    ST_RECALL  = 4'b0000,
    ST_IDLE    = 4'b0001,
    ST_ADDR    = 4'b0010,
    ST_CMD     = 4'b0011,
    ST_DATA    = 4'b0100,
    ST_READ    = 4'b0101,
    ST_IGNORE  = 4'b0110,
    ST_NVWRITE = 4'b0111
  } twsp_state_t;

  // Synchronised pin levels
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       tgl;
    logic       bit_v;
    logic       wp_n;
    logic [2:0] strap;
  } twsp_pins_t;

  // Nonvolatile write request
  typedef struct packed {
    logic [SEL_W-1:0]  addr;
    logic [WPOS_W-1:0] data;
  } twsp_nvw_t;

endpackage

/* File: design/twsp_store.sv */
// Stored-setting registers with registered read port
`timescale 1ns/1ps
module twsp_store (
  input  wire logic                           clk_i,
  input  wire logic                           nrst_i,
  input  wire logic                           ce_i,
  input  wire logic                           wr_en_i,
  input  wire twsp_pkg::twsp_nvw_t            wr_i,
  input  wire logic [twsp_pkg::SEL_W-1:0]     rd_addr_i,
  output logic      [twsp_pkg::WPOS_W-1:0]    rd_data_o
);

  logic [twsp_pkg::WPOS_W-1:0] mem_r [twsp_pkg::NUM_STORE];

  // Reset stands in for the retained contents of the cells
  genvar g;
  generate
    for (g = 0; g < twsp_pkg::NUM_STORE; g++) begin : g_cell
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mem_r[g] <= twsp_pkg::STORE_RST;
        end else if (ce_i && wr_en_i && (wr_i.addr == g)) begin
          mem_r[g] <= wr_i.data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= twsp_pkg::STORE_RST;
    end else if (ce_i) begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end

endmodule

/* File: design/twsp_top.sv */
// Two-wire bus slave that sets a 64-position wiper
`timescale 1ns/1ps
module twsp_top #(
  parameter int NVWRITE_CYC = twsp_pkg::NVWRITE_CYCLES
) (
  input  wire logic                            clk_i,
  input  wire logic                            nrst_i,
  input  wire logic                            ce_i,
  input  wire logic                            scl_clk_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_o,
  input  wire logic                            addr_strap_bit0_i,
  input  wire logic                            addr_strap_bit2_i,
  input  wire logic                            addr_strap_bit3_i,
  input  wire logic                            wr_prot_n_i,
  output logic      [twsp_pkg::NUM_TAPS-1:0]   tap_sel_o,
  output logic      [twsp_pkg::WPOS_W-1:0]     wiper_position_reg_o,
  output logic                                 nv_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: capture each bit on the rising serial clock

  logic bit_l;
  logic tgl_l;

  always_ff @(posedge scl_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_l <= 1'b0;
      tgl_l <= 1'b0;
    end else begin
      bit_l <= sda_i;
      tgl_l <= ~tgl_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing: bit and toggle pass the same two flops, so the bit reaches
  // s2_r in the same clock cycle as the toggle it travels with

  twsp_pkg::twsp_pins_t pin_raw;
  twsp_pkg::twsp_pins_t s1_r;
  twsp_pkg::twsp_pins_t s2_r;
  twsp_pkg::twsp_pins_t prev_r;

  assign pin_raw = '{scl: scl_clk_i, sda: sda_i, tgl: tgl_l, bit_v: bit_l, wp_n: wr_prot_n_i,
                     strap: {addr_strap_bit3_i, addr_strap_bit2_i, addr_strap_bit0_i}};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r   <= '0;
      s2_r   <= '0;
      prev_r <= '0;
    end else if (ce_i) begin
      s1_r   <= pin_raw;
      s2_r   <= s1_r;
      prev_r <= s2_r;
    end
  end

  logic start_ev;
  logic stop_ev;
  logic bit_ev;
  logic scl_fall;

  assign start_ev = s2_r.scl && prev_r.scl && prev_r.sda && !s2_r.sda;
  assign stop_ev  = s2_r.scl && prev_r.scl && !prev_r.sda && s2_r.sda;
  assign bit_ev   = s2_r.tgl ^ prev_r.tgl;
  assign scl_fall = prev_r.scl && !s2_r.scl;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [twsp_pkg::NUM_TAPS-1:0] onehot(input logic [twsp_pkg::WPOS_W-1:0] pos);
    logic [twsp_pkg::NUM_TAPS-1:0] v;
    v      = '0;
    v[pos] = 1'b1;
    return v;
  endfunction

  function automatic logic cmd_valid(input logic [7:0] b);
    logic [3:0] op;
    op = b[twsp_pkg::OP_MSB:twsp_pkg::OP_LSB];
    case (op)
      twsp_pkg::OP_RD_WPOS,
      twsp_pkg::OP_WR_WPOS:  cmd_valid = (b[3:0] == 4'h0);
      twsp_pkg::OP_RD_STORE,
      twsp_pkg::OP_WR_STORE,
      twsp_pkg::OP_XFR_LOAD,
      twsp_pkg::OP_XFR_SAVE: cmd_valid = (b[1:0] == 2'h0);
      twsp_pkg::OP_STEP:     cmd_valid = (b[3:1] == 3'h0);
      default:               cmd_valid = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly

  twsp_pkg::twsp_state_t st_r;
  twsp_pkg::twsp_state_t st_nxt;
  logic [3:0]                    cnt_r;
  logic [6:0]                    sh_r;
  logic [7:0]                    byte_v;
  logic                          rx_state;
  logic                          byte_done;
  logic                          ack_nxt;
  logic                          addr_ok;
  logic [3:0]                    op_r;
  logic [twsp_pkg::SEL_W-1:0]    sel_r;
  logic                          ack_pend_r;
  logic                          oe_r;
  logic                          nv_pend_r;
  twsp_pkg::twsp_nvw_t           nv_req_r;
  logic                          nv_we;
  logic [twsp_pkg::NVWRITE_CNT_W-1:0] tmr_r;
  logic [1:0]                    xfr_dly_r;
  logic [twsp_pkg::WPOS_W-1:0]   wcr_r;
  logic [twsp_pkg::WPOS_W-1:0]   mem_rd;
  logic [7:0]                    tx_w;
  logic [twsp_pkg::NUM_TAPS-1:0] tap_r;

  assign byte_v    = {sh_r, s2_r.bit_v};
  assign rx_state  = (st_r == twsp_pkg::ST_ADDR) || (st_r == twsp_pkg::ST_CMD) ||
                     (st_r == twsp_pkg::ST_DATA);
  assign byte_done = rx_state && bit_ev && !start_ev && !stop_ev && (cnt_r == 4'h7);

  assign addr_ok = (byte_v[twsp_pkg::ID_MSB:twsp_pkg::ID_LSB] == twsp_pkg::DEV_TYPE_ID) &&
                   (byte_v[twsp_pkg::ADR_BIT3_POS] == s2_r.strap[2]) &&
                   (byte_v[twsp_pkg::ADR_BIT2_POS] == s2_r.strap[1]) &&
                   (byte_v[twsp_pkg::ADR_BIT1_POS] == twsp_pkg::ADDR_BIT1) &&
                   (byte_v[twsp_pkg::ADR_BIT0_POS] == s2_r.strap[0]);

  // Shift register and bit count; only the count is restarted by a start
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 4'h0;
      sh_r  <= 7'h00;
    end else if (ce_i) begin
      if (start_ev) begin
        cnt_r <= 4'h0;
      end else if (bit_ev) begin
        if (cnt_r == 4'h8) begin
          cnt_r <= 4'h0;
        end else begin
          cnt_r <= cnt_r + 4'h1;
          sh_r  <= byte_v[6:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state at the end of a received byte

  always_comb begin
    st_nxt  = twsp_pkg::ST_IGNORE;
    ack_nxt = 1'b0;
    case (st_r)
      twsp_pkg::ST_ADDR: begin
        if (addr_ok) begin
          st_nxt  = twsp_pkg::ST_CMD;
          ack_nxt = 1'b1;
        end
      end
      twsp_pkg::ST_CMD: begin
        if (cmd_valid(byte_v)) begin
          ack_nxt = 1'b1;
          case (byte_v[twsp_pkg::OP_MSB:twsp_pkg::OP_LSB])
            twsp_pkg::OP_RD_WPOS,
            twsp_pkg::OP_RD_STORE: st_nxt = twsp_pkg::ST_READ;
            twsp_pkg::OP_WR_WPOS,
            twsp_pkg::OP_WR_STORE: st_nxt = twsp_pkg::ST_DATA;
            default:               st_nxt = twsp_pkg::ST_IGNORE;
          endcase
        end
      end
      twsp_pkg::ST_DATA: begin
        ack_nxt = 1'b1;
      end
      default: begin
        st_nxt  = twsp_pkg::ST_IGNORE;
        ack_nxt = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= twsp_pkg::ST_RECALL;
    end else if (ce_i) begin
      case (st_r)
        twsp_pkg::ST_RECALL: begin
          if (xfr_dly_r[0]) begin
            st_r <= twsp_pkg::ST_IDLE;
          end
        end
        twsp_pkg::ST_NVWRITE: begin
          // Bus is deaf here, so polling addresses go unanswered
          if (tmr_r == '0) begin
            st_r <= twsp_pkg::ST_IDLE;
          end
        end
        default: begin
          if (start_ev) begin
            st_r <= twsp_pkg::ST_ADDR;
          end else if (stop_ev) begin
            st_r <= (nv_pend_r && s2_r.wp_n) ? twsp_pkg::ST_NVWRITE :
                                                twsp_pkg::ST_IDLE;
          end else if (byte_done) begin
            st_r <= st_nxt;
          end else if ((st_r == twsp_pkg::ST_READ) && bit_ev && (cnt_r == 4'h7)) begin
            st_r <= twsp_pkg::ST_IGNORE;
          end
        end
      endcase
    end
  end

  // Command and register select of the current transaction
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_r  <= 4'h0;
      sel_r <= '0;
    end else if (ce_i && byte_done && (st_r == twsp_pkg::ST_CMD)) begin
      op_r  <= byte_v[twsp_pkg::OP_MSB:twsp_pkg::OP_LSB];
      sel_r <= byte_v[twsp_pkg::RSEL_MSB:twsp_pkg::RSEL_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line driver: only ever pulls low, changes on clock falls; released at start, stop and during the write cycle

  assign tx_w = (op_r == twsp_pkg::OP_RD_STORE) ? {2'b00, mem_rd} : {2'b00, wcr_r};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_pend_r <= 1'b0;
      oe_r       <= 1'b0;
    end else if (ce_i) begin
      if (start_ev || stop_ev || (st_r == twsp_pkg::ST_NVWRITE)) begin
        ack_pend_r <= 1'b0;
        oe_r       <= 1'b0;
      end else if (byte_done) begin
        ack_pend_r <= ack_nxt;
      end else if (scl_fall) begin
        if (ack_pend_r) begin
          ack_pend_r <= 1'b0;
          oe_r       <= 1'b1;
        end else if ((st_r == twsp_pkg::ST_READ) && (cnt_r < 4'h8)) begin
          oe_r <= ~tx_w[3'h7 - cnt_r[2:0]];
        end else begin
          oe_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile write request and busy timer

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_pend_r <= 1'b0;
      nv_req_r  <= '0;
    end else if (ce_i) begin
      if (start_ev || stop_ev) begin
        nv_pend_r <= 1'b0;
      end else if (byte_done && (st_r == twsp_pkg::ST_DATA) && (op_r == twsp_pkg::OP_WR_STORE)) begin
        nv_pend_r <= 1'b1;
        nv_req_r  <= '{addr: sel_r, data: byte_v[twsp_pkg::WPOS_W-1:0]};
      end else if (byte_done && (st_r == twsp_pkg::ST_CMD) && cmd_valid(byte_v) &&
                   (byte_v[twsp_pkg::OP_MSB:twsp_pkg::OP_LSB] == twsp_pkg::OP_XFR_SAVE)) begin
        nv_pend_r <= 1'b1;
        nv_req_r  <= '{addr: byte_v[twsp_pkg::RSEL_MSB:twsp_pkg::RSEL_LSB], data: wcr_r};
      end
    end
  end

  // Cells change only at the end of the busy time, and only if unprotected at the stop
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmr_r <= '0;
    end else if (ce_i) begin
      if ((st_r != twsp_pkg::ST_NVWRITE) && stop_ev && nv_pend_r && s2_r.wp_n) begin
        tmr_r <= twsp_pkg::NVWRITE_CNT_W'(NVWRITE_CYC - 1);
      end else if ((st_r == twsp_pkg::ST_NVWRITE) && (tmr_r != '0)) begin
        tmr_r <= tmr_r - 1'b1;
      end
    end
  end

  assign nv_we = (st_r == twsp_pkg::ST_NVWRITE) && (tmr_r == '0);

  twsp_store u_store (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .wr_en_i   (nv_we),
    .wr_i      (nv_req_r),
    .rd_addr_i (sel_r),
    .rd_data_o (mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wiper position and tap select

  // Read port is one flop behind a select change, which is itself registered, hence the delay line
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xfr_dly_r <= 2'b10;
    end else if (ce_i) begin
      if (byte_done && (st_r == twsp_pkg::ST_CMD) && cmd_valid(byte_v) &&
          (byte_v[twsp_pkg::OP_MSB:twsp_pkg::OP_LSB] == twsp_pkg::OP_XFR_LOAD)) begin
        xfr_dly_r <= 2'b10;
      end else begin
        xfr_dly_r <= {1'b0, xfr_dly_r[1]};
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wcr_r <= twsp_pkg::WPOS_RST;
    end else if (ce_i) begin
      if (xfr_dly_r[0]) begin
        wcr_r <= mem_rd;
      end else if (byte_done && (st_r == twsp_pkg::ST_DATA) && (op_r == twsp_pkg::OP_WR_WPOS)) begin
        wcr_r <= byte_v[twsp_pkg::WPOS_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tap_r <= twsp_pkg::TAP_RST;
    end else if (ce_i) begin
      tap_r <= onehot(wcr_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sda_o                = 1'b0;
  assign sda_oe_o             = oe_r;
  assign tap_sel_o            = tap_r;
  assign wiper_position_reg_o = wcr_r;
  assign nv_busy_o            = (st_r == twsp_pkg::ST_NVWRITE);

endmodule
